// ### core/mda_pkg.sv
// Purpose: Constants and types of the motion data acquisition unit
// Assumes: 10 MHz APB clock, 32-bit APB data
// Notes: Buffer window holds 2000 words per channel
package mda_pkg;
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned NUM_AXES = 12;
	localparam int unsigned BUF_DEPTH = 2000;
	localparam logic [10:0] REQ_MAX = 11'h7D0;
	localparam logic [10:0] REQ_RESET = 11'h7D0;
	localparam logic [7:0] PERIOD_RESET = 8'h0A;
	// Time base
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	// Register offsets (byte addresses)
	localparam logic [15:0] OFS_CTRL = 16'h0000;
	localparam logic [15:0] OFS_PERIOD = 16'h0004;
	localparam logic [15:0] OFS_IRQ_STAT = 16'h0008;
	localparam logic [15:0] OFS_IRQ_MASK = 16'h000C;
	localparam logic [15:0] OFS_CH_BASE = 16'h0010;
	localparam logic [15:0] OFS_CH_END = 16'h0050;
	localparam logic [15:0] OFS_BUF_BASE = 16'h8000;
	localparam logic [1:0] CH_CFG = 2'h0;
	localparam logic [1:0] CH_REQ = 2'h1;
	localparam logic [1:0] CH_STAT = 2'h2;
	// Control bits
	localparam int unsigned CTRL_ARM = 0;
	localparam int unsigned CTRL_HALT = 1;
	// Channel configuration fields
	localparam int unsigned CFG_AXIS_LSB = 0;
	localparam int unsigned CFG_TRIG_LSB = 4;
	localparam int unsigned CFG_SRC_LSB = 8;
	localparam int unsigned CFG_PER_LSB = 16;
	// Channel status fields
	localparam int unsigned STAT_ST_LSB = 0;
	localparam int unsigned STAT_CAP_LSB = 16;
	localparam int unsigned STAT_IDX_LSB = 28;
	// Interrupt bits: done in [3:0], triggered in [7:4]
	localparam int unsigned IRQ_TRIG_LSB = 4;
	// Trigger methods
	localparam logic [3:0] TRIG_OFF = 4'h0;
	localparam logic [3:0] TRIG_SOFTWARE = 4'h1;
	localparam logic [3:0] TRIG_DIGITAL_INPUT = 4'h2;
	localparam logic [3:0] TRIG_AXIS_FIRST = 4'h3;
	localparam logic [3:0] TRIG_AXIS_LAST = 4'hE;
	// Sample sources
	localparam logic [1:0] SRC_CMD = 2'h0;
	localparam logic [1:0] SRC_ACT = 2'h1;
	localparam logic [1:0] SRC_LAG = 2'h2;
	localparam logic [1:0] SRC_CMD_VEL = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ACTIVE} mda_state_t;

	typedef struct packed {
		logic [7:0] period;
		logic [15:0] ms_cnt;
		logic [7:0] per_cnt;
		logic [3:0][3:0] axis;
		logic [3:0][3:0] trig;
		logic [3:0][1:0] src;
		logic [3:0][10:0] req;
		logic [3:0][10:0] cap;
		mda_state_t [3:0] st;
		logic [11:0] moving_q;
		logic [7:0] irq_stat;
		logic [7:0] irq_mask;
		logic ack;
		logic [31:0] rdata;
	} mda_regs_t;
endpackage : mda_pkg

// ### core/mda_top.sv
// Purpose: Four-channel motion data capture with APB registers and buffers
// Assumes: Axis positions and moving flags come from logic on pclk
// Notes: Every APB transfer answers in the second access cycle
// How it works
// - Four channels, each with own axis, trigger, source, count and status.
// - Each channel may pick any axis as its data source.
// - Sample interval is 1 to 255 ms; one sample per interval.
// - One interval shared; writing it through any channel changes all.
// - Trigger 0 keeps the channel idle even on arm.
// - Trigger 1 starts sampling at once on arm.
// - Trigger 2 is reserved; never starts acquisition.
// - Triggers 3 to 14 start when axis code minus three starts moving.
// - Source 0 command position, 1 actual position; 3 unsupported.
// - Source 2 samples command minus actual position.
// - Requested count 0 to 2000, default 2000.
// - Captured count readable during and after capture.
// - Status 0 idle, 1 armed, 2 sampling.
// - Arm command arms axis-trigger channels; each waits for its axis to start moving.
// - Halt command stops sampling on every channel.
// - Index, captured count and status read-only; other settings writable.
`timescale 1ns/1ps
`default_nettype none
module mda_top
	import mda_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [11:0][31:0] cmd_pos,
	input wire logic [11:0][31:0] act_pos,
	input wire logic [11:0] axis_moving,
	output logic irq
);
	mda_regs_t r;
	mda_regs_t n;
	logic [31:0] mem [NUM_CH][BUF_DEPTH];
	logic [3:0] wr_en;
	logic [3:0][10:0] wr_idx;
	logic [3:0][31:0] wr_dat;
	logic done;
	logic wr_ok;
	logic arm;
	logic halt;
	logic ms_tick;
	logic sample_stb;
	logic is_ch;
	logic is_buf;
	logic mapped;
	logic [1:0] sel_ch;
	logic [1:0] sel_reg;
	logic [1:0] buf_ch;
	logic [10:0] buf_idx;
	logic [31:0] rd_val;
	logic [3:0] mv_rise;

	function automatic logic [31:0] pick_sample(input logic [1:0] src,
			input logic [31:0] cmd, input logic [31:0] act);
		logic [31:0] v;
		v = 32'h0;
		unique case (src)
			SRC_CMD: v = cmd;
			SRC_ACT: v = act;
			SRC_LAG: v = cmd - act;
			SRC_CMD_VEL: v = 32'h0;
		endcase
		return v;
	endfunction : pick_sample

	function automatic logic trig_axis(input logic [3:0] t);
		return (t >= TRIG_AXIS_FIRST) && (t <= TRIG_AXIS_LAST);
	endfunction : trig_axis

	function automatic logic [3:0] axis_of_trig(input logic [3:0] t);
		return t - TRIG_AXIS_FIRST;
	endfunction : axis_of_trig

	// APB decode
	assign done = psel && penable && r.ack;
	assign wr_ok = done && pwrite && mapped;
	assign is_ch = !paddr[15] && (paddr >= OFS_CH_BASE) && (paddr < OFS_CH_END);
	assign is_buf = paddr[15];
	assign sel_ch = paddr[5:4] - 2'h1;
	assign sel_reg = paddr[3:2];
	assign buf_ch = paddr[14:13];
	assign buf_idx = paddr[12:2];
	assign mapped = (paddr[1:0] == 2'h0) && (is_buf || (paddr == OFS_CTRL)
		|| (paddr == OFS_PERIOD) || (paddr == OFS_IRQ_STAT)
		|| (paddr == OFS_IRQ_MASK) || (is_ch && sel_reg != 2'h3));
	assign pready = done;
	assign pslverr = done && !mapped;
	assign prdata = r.rdata;
	assign irq = |(r.irq_stat & r.irq_mask);
	assign arm = wr_ok && paddr == OFS_CTRL && pwdata[CTRL_ARM];
	assign halt = wr_ok && paddr == OFS_CTRL && pwdata[CTRL_HALT];
	assign ms_tick = r.ms_cnt >= 16'(MS_CYCLES - 1);
	assign sample_stb = ms_tick && (r.per_cnt >= r.period - 8'h1);

	always_comb begin
		rd_val = 32'h0;
		if (is_buf) begin
			if (buf_idx < 11'(BUF_DEPTH)) begin
				rd_val = mem[buf_ch][buf_idx];
			end
		end else if (paddr == OFS_PERIOD) begin
			rd_val[7:0] = r.period;
		end else if (paddr == OFS_IRQ_STAT) begin
			rd_val[7:0] = r.irq_stat;
		end else if (paddr == OFS_IRQ_MASK) begin
			rd_val[7:0] = r.irq_mask;
		end else if (is_ch) begin
			unique case (sel_reg)
				CH_CFG: begin
					rd_val[CFG_AXIS_LSB +: 4] = r.axis[sel_ch];
					rd_val[CFG_TRIG_LSB +: 4] = r.trig[sel_ch];
					rd_val[CFG_SRC_LSB +: 2] = r.src[sel_ch];
					rd_val[CFG_PER_LSB +: 8] = r.period;
				end
				CH_REQ: rd_val[10:0] = r.req[sel_ch];
				CH_STAT: begin
					rd_val[STAT_ST_LSB +: 2] = r.st[sel_ch];
					rd_val[STAT_CAP_LSB +: 11] = r.cap[sel_ch];
					rd_val[STAT_IDX_LSB +: 2] = sel_ch;
				end
				default: rd_val = 32'h0;
			endcase
		end
	end

	always_comb begin
		n = r;
		wr_en = 4'h0;
		wr_idx = '0;
		wr_dat = '0;
		mv_rise = 4'h0;
		n.moving_q = axis_moving;
		// APB: one wait state, read data loaded in first access cycle
		n.ack = psel && penable && !r.ack;
		if (psel && penable && !r.ack && !pwrite) begin
			n.rdata = mapped ? rd_val : 32'h0;
		end
		// Millisecond and interval counters
		n.ms_cnt = ms_tick ? 16'h0 : r.ms_cnt + 16'h1;
		if (sample_stb) begin
			n.per_cnt = 8'h0;
		end else if (ms_tick) begin
			n.per_cnt = r.per_cnt + 8'h1;
		end
		if (arm) begin
			n.ms_cnt = 16'h0;
			n.per_cnt = 8'h0;
		end
		// Register writes; status and count fields ignore writes
		if (wr_ok && paddr == OFS_PERIOD && pwdata[7:0] != 8'h0) begin
			n.period = pwdata[7:0];
		end
		if (wr_ok && paddr == OFS_IRQ_MASK) begin
			n.irq_mask = pwdata[7:0];
		end
		if (wr_ok && is_ch && sel_reg == CH_CFG) begin
			n.axis[sel_ch] = pwdata[CFG_AXIS_LSB +: 4];
			n.trig[sel_ch] = pwdata[CFG_TRIG_LSB +: 4];
			n.src[sel_ch] = pwdata[CFG_SRC_LSB +: 2];
			if (pwdata[CFG_PER_LSB +: 8] != 8'h0) begin
				n.period = pwdata[CFG_PER_LSB +: 8];
			end
		end
		if (wr_ok && is_ch && sel_reg == CH_REQ) begin
			n.req[sel_ch] = (pwdata[10:0] > REQ_MAX || pwdata[31:11] != '0)
				? REQ_MAX : pwdata[10:0];
		end
		if (wr_ok && paddr == OFS_IRQ_STAT) begin
			n.irq_stat = r.irq_stat & ~pwdata[7:0];
		end
		// Channel engines
		for (int c = 0; c < NUM_CH; c++) begin
			mv_rise[c] = trig_axis(r.trig[c])
				&& axis_moving[axis_of_trig(r.trig[c])]
				&& !r.moving_q[axis_of_trig(r.trig[c])];
			unique case (r.st[c])
				ST_IDLE: begin
					// Off, reserved trigger and reserved source stay idle
					if (arm && r.src[c] != SRC_CMD_VEL) begin
						if (r.trig[c] == TRIG_SOFTWARE) begin
							n.st[c] = ST_ACTIVE;
							n.cap[c] = 11'h0;
							n.irq_stat[IRQ_TRIG_LSB + c] = 1'b1;
						end else if (trig_axis(r.trig[c])) begin
							n.st[c] = ST_ARMED;
							n.cap[c] = 11'h0;
						end
					end
				end
				ST_ARMED: begin
					if (mv_rise[c]) begin
						n.st[c] = ST_ACTIVE;
						n.irq_stat[IRQ_TRIG_LSB + c] = 1'b1;
					end
				end
				ST_ACTIVE: begin
					if (r.cap[c] >= r.req[c]) begin
						n.st[c] = ST_IDLE;
						n.irq_stat[c] = 1'b1;
					end else if (sample_stb) begin
						wr_en[c] = 1'b1;
						wr_idx[c] = r.cap[c];
						wr_dat[c] = (r.axis[c] < 4'(NUM_AXES))
							? pick_sample(r.src[c], cmd_pos[r.axis[c]],
								act_pos[r.axis[c]]) : 32'h0;
						n.cap[c] = r.cap[c] + 11'h1;
					end
				end
				default: n.st[c] = ST_IDLE;
			endcase
			if (halt) begin
				n.st[c] = ST_IDLE;
				wr_en[c] = 1'b0;
				n.cap[c] = r.cap[c];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.period <= PERIOD_RESET;
			for (int c = 0; c < NUM_CH; c++) begin
				r.req[c] <= REQ_RESET;
				r.st[c] <= ST_IDLE;
			end
		end else begin
			r <= n;
		end
	end

	always_ff @(posedge pclk) begin
		for (int c = 0; c < NUM_CH; c++) begin
			if (wr_en[c]) begin
				mem[c][wr_idx[c]] <= wr_dat[c];
			end
		end
	end

	// Checks on single channels and shared logic
	sequence seq_arm_sw;
		arm && !halt && r.st[0] == ST_IDLE && r.trig[0] == TRIG_SOFTWARE
			&& r.src[0] != SRC_CMD_VEL;
	endsequence
	sequence seq_full;
		r.st[0] == ST_ACTIVE && r.cap[0] >= r.req[0] && !halt;
	endsequence

	a_off_stays_idle: assert property (@(posedge pclk) disable iff (!presetn)
		r.st[2] == ST_IDLE && r.trig[2] == TRIG_OFF |=> r.st[2] == ST_IDLE)
		else $error("disabled channel left idle");
	a_sw_starts_now: assert property (@(posedge pclk) disable iff (!presetn)
		seq_arm_sw |=> r.st[0] == ST_ACTIVE && r.cap[0] == 11'h0)
		else $error("software trigger did not start sampling");
	a_di_never_runs: assert property (@(posedge pclk) disable iff (!presetn)
		r.st[3] == ST_IDLE && r.trig[3] == TRIG_DIGITAL_INPUT |=> r.st[3] == ST_IDLE)
		else $error("reserved trigger started a channel");
	a_axis_wait: assert property (@(posedge pclk) disable iff (!presetn)
		r.st[0] == ST_ARMED && !halt |=> r.st[0] == ($past(mv_rise[0])
			? ST_ACTIVE : ST_ARMED))
		else $error("axis trigger wrong");
	a_halt_all_idle: assert property (@(posedge pclk) disable iff (!presetn)
		halt |=> r.st == {NUM_CH{ST_IDLE}} ##1 r.st == {NUM_CH{ST_IDLE}})
		else $error("halt left a channel running");
	a_full_to_idle: assert property (@(posedge pclk) disable iff (!presetn)
		seq_full |=> r.st[0] == ST_IDLE && r.irq_stat[0])
		else $error("full channel kept sampling");
	a_period_shared: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && is_ch && sel_reg == CH_CFG && pwdata[CFG_PER_LSB +: 8] != 8'h0
		|=> r.period == $past(pwdata[CFG_PER_LSB +: 8]))
		else $error("channel write did not set shared interval");
	a_cap_steps: assert property (@(posedge pclk) disable iff (!presetn)
		r.st[0] == ST_ACTIVE && r.cap[0] < r.req[0] && sample_stb && !halt
		|=> r.cap[0] == $past(r.cap[0]) + 11'h1 ##1 r.cap[0] == $past(r.cap[0]))
		else $error("captured count did not step once per sample");
	a_stb_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		sample_stb && !arm |=> !sample_stb)
		else $error("two samples in consecutive cycles");

	// Shared checks on interval, count and status writes
	sequence seq_req_big;
		wr_ok && is_ch && sel_reg == CH_REQ && pwdata > 32'(REQ_MAX);
	endsequence
	a_req_clamp: assert property (@(posedge pclk) disable iff (!presetn)
		seq_req_big |=> r.req[$past(sel_ch)] == REQ_MAX)
		else $error("requested count not clamped");
	a_period_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && paddr == OFS_PERIOD && pwdata[7:0] != 8'h0
		|=> r.period == $past(pwdata[7:0]))
		else $error("interval write lost");
	a_period_zero: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && paddr == OFS_PERIOD && pwdata[7:0] == 8'h0
		|=> r.period == $past(r.period))
		else $error("zero interval accepted");
	a_stat_ro: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok && is_ch && sel_reg == CH_STAT && !sample_stb
		|=> r.cap == $past(r.cap))
		else $error("status write changed a count");

	// Checks repeated on every channel
	for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
		sequence seq_arm_now;
			arm && !halt && r.st[g] == ST_IDLE && r.trig[g] == TRIG_SOFTWARE
				&& r.src[g] != SRC_CMD_VEL;
		endsequence
		sequence seq_arm_axis;
			arm && !halt && r.st[g] == ST_IDLE && trig_axis(r.trig[g])
				&& r.src[g] != SRC_CMD_VEL;
		endsequence
		sequence seq_rise;
			r.st[g] == ST_ARMED && mv_rise[g] && !halt;
		endsequence
		sequence seq_lag_sample;
			r.st[g] == ST_ACTIVE && r.cap[g] < r.req[g] && sample_stb && !halt
				&& r.src[g] == SRC_LAG && r.axis[g] < 4'(NUM_AXES);
		endsequence

		// Arm, trigger and halt
		a_arm_runs: assert property (@(posedge pclk) disable iff (!presetn)
			seq_arm_now |=> r.st[g] == ST_ACTIVE && r.irq_stat[IRQ_TRIG_LSB + g])
			else $error("software trigger missed");
		a_arm_waits: assert property (@(posedge pclk) disable iff (!presetn)
			seq_arm_axis |=> r.st[g] == ST_ARMED && r.cap[g] == 11'h0)
			else $error("axis trigger channel not armed");
		a_armed_hold: assert property (@(posedge pclk) disable iff (!presetn)
			r.st[g] == ST_ARMED && !mv_rise[g] && !halt |=> r.st[g] == ST_ARMED)
			else $error("channel left armed without its trigger");
		a_rise_starts: assert property (@(posedge pclk) disable iff (!presetn)
			seq_rise |=> r.st[g] == ST_ACTIVE && r.irq_stat[IRQ_TRIG_LSB + g])
			else $error("axis motion did not start sampling");
		a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
			r.st[g] == ST_IDLE && (r.trig[g] == TRIG_OFF || r.trig[g] == TRIG_DIGITAL_INPUT)
			|=> r.st[g] == ST_IDLE)
			else $error("disabled channel started");
		a_src_reserved: assert property (@(posedge pclk) disable iff (!presetn)
			r.st[g] == ST_IDLE && r.src[g] == SRC_CMD_VEL |=> r.st[g] == ST_IDLE)
			else $error("reserved source started a channel");
		a_halt_freeze: assert property (@(posedge pclk) disable iff (!presetn)
			halt |=> r.st[g] == ST_IDLE && r.cap[g] == $past(r.cap[g]))
			else $error("halt did not freeze the channel");

		// Data path and counters
		a_lag_data: assert property (@(posedge pclk) disable iff (!presetn)
			seq_lag_sample |-> wr_en[g]
				&& wr_dat[g] == cmd_pos[r.axis[g]] - act_pos[r.axis[g]])
			else $error("lag sample wrong");
		a_write_active: assert property (@(posedge pclk) disable iff (!presetn)
			wr_en[g] |=> r.cap[g] == $past(r.cap[g]) + 11'h1 && r.st[g] == ST_ACTIVE)
			else $error("buffer write without count step");
		a_cap_frozen: assert property (@(posedge pclk) disable iff (!presetn)
			r.st[g] != ST_ACTIVE && !arm |=> r.cap[g] == $past(r.cap[g]))
			else $error("captured count moved outside capture");
		a_req_bound: assert property (@(posedge pclk) disable iff (!presetn)
			r.req[g] <= REQ_MAX)
			else $error("requested count above limit");
		a_state_legal: assert property (@(posedge pclk) disable iff (!presetn)
			r.st[g] inside {ST_IDLE, ST_ARMED, ST_ACTIVE})
			else $error("channel status code illegal");
	end : g_chk
endmodule : mda_top
`default_nettype wire

// ### sim/mda_axis_model.sv
// Purpose: Axis motion generators feeding the capture unit
// Assumes: Positions hold still; only the moving flags change
// Notes: Command 0x100*(a+1), actual 0x10*(a+1) per axis a
`timescale 1ns/1ps
`default_nettype none
module mda_axis_model
	import mda_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] move_req,
	output logic [11:0][31:0] cmd_pos,
	output logic [11:0][31:0] act_pos,
	output logic [11:0] axis_moving
);
	always_comb begin
		for (int a = 0; a < 12; a++) begin
			cmd_pos[a] = 32'(32'h100 * (a + 1));
			act_pos[a] = 32'(32'h10 * (a + 1));
		end
	end
	// Moving flag changes only on a clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) axis_moving <= 12'h000;
		else axis_moving <= move_req;
	end
endmodule : mda_axis_model
`default_nettype wire

// ### sim/tb_motion_data_acquisition.sv
// Purpose: Self-checking bench of the capture unit over APB
// Assumes: Millisecond shortened to 2 clock cycles
// Notes: One idle cycle between APB transfers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_motion_data_acquisition
	import mda_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [11:0][31:0] cmd_pos, act_pos;
	logic [11:0] axis_moving, move_req;
	int n_errors, n_tests, cyc;
	mda_top #(.MS_CYCLES(2)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_pos(cmd_pos), .act_pos(act_pos),
		.axis_moving(axis_moving), .irq(irq));
	mda_axis_model i_axes (.pclk(pclk), .presetn(presetn), .move_req(move_req),
		.cmd_pos(cmd_pos), .act_pos(act_pos), .axis_moving(axis_moving));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		logic rdy;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		rdy = 1'b0;
		while (!rdy) begin
			@(posedge pclk);
			rdy = (pready === 1'b1);
			rd = prdata;
			er = pslverr;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, v, e);
	endtask : wr
	task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string nm);
		logic e;
		apb(1'b0, a, 32'h0000_0000, v, e);
		`CHK(nm, v, exp)
	endtask : rdc
	function automatic logic [15:0] cha(input int c, input int o);
		return 16'(OFS_CH_BASE + 16'h10 * c + 4 * o);
	endfunction : cha
	function automatic logic [31:0] stw(input int c, input int cap, input int s);
		return 32'((c << 28) | (cap << 16) | s);
	endfunction : stw
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		logic e;
		{presetn, psel, penable, pwrite, paddr, pwdata, move_req} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(OFS_PERIOD, 32'h0000_000A, "period reset");
		rdc(cha(2, 1), 32'h0000_07D0, "req reset");
		for (int c = 0; c < 4; c++) rdc(cha(c, 2), stw(c, 0, 0), "stat reset");
		wr(cha(3, 2), 32'h0000_0002);
		rdc(cha(3, 2), stw(3, 0, 0), "stat write");
		wr(OFS_PERIOD, 32'h0000_0005);
		wr(OFS_PERIOD, 32'h0000_0000);
		rdc(OFS_PERIOD, 32'h0000_0005, "period zero ignored");
		wr(cha(2, 1), 32'h0000_0FFF);
		rdc(cha(2, 1), 32'h0000_07D0, "req clamp");
		wr(cha(1, 0), 32'h0003_0000);
		rdc(OFS_PERIOD, 32'h0000_0003, "shared period");
		apb(1'b0, 16'h0060, 32'h0, v, e);
		`CHK("unmapped err", e, 1'b1)
		// Software trigger on ch0/ch1, ch2 off, ch3 reserved trigger
		wr(cha(0, 0), 32'h0000_0015);
		wr(cha(0, 1), 32'h0000_0002);
		wr(cha(1, 0), 32'h0000_0212);
		wr(cha(1, 1), 32'h0000_0002);
		rdc(cha(1, 0), 32'h0003_0212, "cfg readback");
		wr(cha(3, 0), 32'h0000_0020);
		wr(OFS_IRQ_MASK, 32'h0000_00FF);
		wr(OFS_CTRL, 32'h0000_0001);
		rdc(cha(0, 2), stw(0, 0, 2), "sw trig active");
		rdc(cha(2, 2), stw(2, 0, 0), "trig off idle");
		rdc(cha(3, 2), stw(3, 0, 0), "trig di idle");
		repeat (30) @(posedge pclk);
		rdc(cha(0, 2), stw(0, 2, 0), "done count");
		rdc(OFS_BUF_BASE + 16'h0004, 32'h0000_0600, "cmd sample");
		rdc(OFS_BUF_BASE + 16'h2004, 32'h0000_02D0, "lag sample");
		`CHK("irq set", irq, 1'b1)
		wr(OFS_IRQ_STAT, 32'h0000_00FF);
		@(posedge pclk);
		`CHK("irq clear", irq, 1'b0)
		// Axis triggers: ch0 on axis 7, ch1 on axis 1
		wr(cha(0, 0), 32'h0000_01A4);
		wr(cha(0, 1), 32'h0000_0001);
		wr(cha(1, 0), 32'h0000_0040);
		wr(cha(1, 1), 32'h0000_0005);
		wr(cha(2, 0), 32'h0000_0310);
		wr(OFS_CTRL, 32'h0000_0001);
		rdc(cha(0, 2), stw(0, 0, 1), "armed");
		rdc(cha(2, 2), stw(2, 0, 0), "src reserved idle");
		@(posedge pclk);
		move_req <= 12'h080;
		repeat (30) @(posedge pclk);
		rdc(cha(0, 2), stw(0, 1, 0), "axis done");
		rdc(OFS_BUF_BASE, 32'h0000_0050, "act sample");
		rdc(cha(1, 2), stw(1, 0, 1), "still armed");
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		@(posedge pclk);
		`CHK("irq masked", irq, 1'b0)
		wr(OFS_CTRL, 32'h0000_0002);
		rdc(cha(1, 2), stw(1, 0, 0), "halted");
		report_and_stop();
	end
endmodule : tb_motion_data_acquisition
`default_nettype wire
